/* design/nfc_host.sv */
// Purpose: host controller that drives an x8 NAND flash through its pins
// Assumes: APB slave for software, pull-ups on both ready/busy lines
// Notes:   software issues one operation at a time and polls status
//
// Added by the designer: the APB register port and the register addresses.
module nfc_host (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  output nfc_pkg::nfc_pins_t           pins_o,
  input  wire logic [nfc_pkg::IO_W-1:0] io_in,
  input  wire logic                    ready_busy_n,
  input  wire logic                    second_ready_busy_n
);

  nfc_pkg::nfc_seq_t              state_q, state_d;
  nfc_pkg::nfc_op_t               op_q, op_d;
  nfc_pkg::nfc_pins_t             pins_q, pins_d;
  logic [2:0]                     idx_q, idx_d;
  logic [7:0]                     guard_q, guard_d;
  logic                           sel_q, sel_d;
  logic                           wp_n_q, wp_n_d;
  logic [nfc_pkg::IO_W-1:0]       byte_q, byte_d;
  logic [nfc_pkg::IO_W-1:0]       rdata_q, rdata_d;
  logic [nfc_pkg::COL_W-1:0]      col_q, col_d;
  logic [nfc_pkg::ROW_W-1:0]      row_q, row_d;
  logic [31:0]                    prdata_q, prdata_d;
  logic [nfc_pkg::IO_W-1:0]       io_meta_q, io_sync_q;
  logic [1:0]                     rb_meta_q, rb_sync_q;
  logic                           stb_start, stb_n, stb_sample, stb_done;
  logic                           wr_en, hit, rdy_sel;

  // five address bytes; bits above the address are held low
  function automatic logic [7:0] addr_byte(input logic [2:0] i,
                                           input logic [nfc_pkg::COL_W-1:0] col,
                                           input logic [nfc_pkg::ROW_W-1:0] row);
    case (i)
      3'h0:    return col[7:0];
      3'h1:    return {4'h0, col[11:8]};
      3'h2:    return row[7:0];
      3'h3:    return row[15:8];
      default: return {5'h0, row[18:16]};
    endcase
  endfunction : addr_byte

  // ----------------------------------------------------------------
  // pin input synchronisers
  // ----------------------------------------------------------------
  // io bus and ready/busy synchroniser
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      io_meta_q <= 8'h00;
      io_sync_q <= 8'h00;
      rb_meta_q <= 2'h3;
      rb_sync_q <= 2'h3;
    end
    else
    begin
      io_meta_q <= io_in;
      io_sync_q <= io_meta_q;
      rb_meta_q <= {second_ready_busy_n, ready_busy_n};
      rb_sync_q <= rb_meta_q;
    end
  end

  assign rdy_sel = sel_q ? rb_sync_q[1] : rb_sync_q[0];

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign hit     = (paddr == nfc_pkg::OFS_CTRL) || (paddr == nfc_pkg::OFS_DATA) ||
                   (paddr == nfc_pkg::OFS_COL) || (paddr == nfc_pkg::OFS_ROW) ||
                   (paddr == nfc_pkg::OFS_STATUS);
  assign wr_en   = psel && penable && pwrite && hit;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata  = prdata_q;

  // ----------------------------------------------------------------
  // registers and sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    state_d  = state_q;
    op_d     = op_q;
    pins_d   = pins_q;
    idx_d    = idx_q;
    guard_d  = guard_q;
    sel_d    = sel_q;
    wp_n_d   = wp_n_q;
    byte_d   = byte_q;
    rdata_d  = rdata_q;
    col_d    = col_q;
    row_d    = row_q;
    prdata_d = prdata_q;
    stb_start = 1'b0;

    // read data is captured in the setup phase so the access phase needs no wait
    if (psel && !penable && !pwrite)
    begin
      unique case (paddr)
        nfc_pkg::OFS_CTRL:   prdata_d = {26'h0, wp_n_q, sel_q, op_q, 1'b0};
        nfc_pkg::OFS_DATA:   prdata_d = {24'h0, rdata_q};
        nfc_pkg::OFS_COL:    prdata_d = {20'h0, col_q};
        nfc_pkg::OFS_ROW:    prdata_d = {13'h0, row_q};
        nfc_pkg::OFS_STATUS: prdata_d = {29'h0, rb_sync_q, state_q != nfc_pkg::S_IDLE};
        default:             prdata_d = 32'h0;
      endcase
    end

    // configuration is frozen while an operation runs
    if (wr_en && (state_q == nfc_pkg::S_IDLE))
    begin
      unique case (paddr)
        nfc_pkg::OFS_CTRL:
        begin
          op_d   = nfc_pkg::nfc_op_t'(pwdata[nfc_pkg::CTRL_OP_LSB +: 3]);
          sel_d  = pwdata[nfc_pkg::CTRL_SEL];
          wp_n_d = pwdata[nfc_pkg::CTRL_WP];
          pins_d.write_protect_n = pwdata[nfc_pkg::CTRL_WP];
          if (pwdata[nfc_pkg::CTRL_GO])
          begin
            idx_d   = 3'h0;
            guard_d = nfc_pkg::GUARD_CYC - 8'h01;
            state_d = (pwdata[nfc_pkg::CTRL_OP_LSB +: 3] == 3'(nfc_pkg::OP_WAIT)) ?
                      nfc_pkg::S_WAIT : nfc_pkg::S_SETUP;
          end
        end
        nfc_pkg::OFS_DATA: byte_d = pwdata[7:0];
        nfc_pkg::OFS_COL:  col_d  = pwdata[nfc_pkg::COL_W-1:0];
        nfc_pkg::OFS_ROW:  row_d  = pwdata[nfc_pkg::ROW_W-1:0];
        default:           byte_d = byte_q;
      endcase
    end

    unique case (state_q)
      nfc_pkg::S_IDLE:
      begin
        pins_d.chip_select_n        = 1'b1;
        pins_d.second_chip_select_n = 1'b1;
        pins_d.cmd_latch            = 1'b0;
        pins_d.addr_latch           = 1'b0;
        pins_d.io_oe                = 1'b0;
      end
      nfc_pkg::S_SETUP:
      begin
        pins_d.chip_select_n        = sel_q;
        pins_d.second_chip_select_n = !sel_q;
        pins_d.cmd_latch            = (op_q == nfc_pkg::OP_CMD);
        pins_d.addr_latch           = (op_q == nfc_pkg::OP_ADDR);
        pins_d.io_out               = (op_q == nfc_pkg::OP_ADDR) ? addr_byte(idx_q, col_q, row_q) : byte_q;
        pins_d.io_oe                = (op_q != nfc_pkg::OP_READ);
        state_d                     = nfc_pkg::S_LAUNCH;
      end
      nfc_pkg::S_LAUNCH:
      begin
        stb_start = 1'b1;
        state_d   = nfc_pkg::S_STROBE;
      end
      nfc_pkg::S_STROBE:
      begin
        if (stb_sample && (op_q == nfc_pkg::OP_READ))
        begin
          rdata_d = io_sync_q;
        end
        if (stb_done)
        begin
          if ((op_q == nfc_pkg::OP_ADDR) && (idx_q != nfc_pkg::ADDR_LAST))
          begin
            idx_d   = idx_q + 3'h1;
            state_d = nfc_pkg::S_SETUP;
          end
          else
          begin
            state_d = nfc_pkg::S_IDLE;
          end
        end
      end
      nfc_pkg::S_WAIT:
      begin
        // select stays high while the device works
        pins_d.chip_select_n        = 1'b1;
        pins_d.second_chip_select_n = 1'b1;
        // next command only after ready returns
        if (guard_q != 8'h00)
        begin
          guard_d = guard_q - 8'h01;
        end
        else if (rdy_sel)
        begin
          state_d = nfc_pkg::S_IDLE;
        end
      end
      default:
      begin
        state_d = nfc_pkg::S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q  <= nfc_pkg::S_IDLE;
      op_q     <= nfc_pkg::OP_CMD;
      pins_q   <= '{chip_select_n: 1'b1, second_chip_select_n: 1'b1, cmd_latch: 1'b0, addr_latch: 1'b0,
                    write_strobe_n: 1'b1, read_strobe_n: 1'b1, write_protect_n: nfc_pkg::RST_WP_N,
                    io_out: 8'h00, io_oe: 1'b0};
      idx_q    <= 3'h0;
      guard_q  <= 8'h00;
      sel_q    <= nfc_pkg::RST_SEL;
      wp_n_q   <= nfc_pkg::RST_WP_N;
      byte_q   <= 8'h00;
      rdata_q  <= 8'h00;
      col_q    <= '0;
      row_q    <= '0;
      prdata_q <= 32'h0;
    end
    else
    begin
      state_q  <= state_d;
      op_q     <= op_d;
      pins_q   <= pins_d;
      idx_q    <= idx_d;
      guard_q  <= guard_d;
      sel_q    <= sel_d;
      wp_n_q   <= wp_n_d;
      byte_q   <= byte_d;
      rdata_q  <= rdata_d;
      col_q    <= col_d;
      row_q    <= row_d;
      prdata_q <= prdata_d;
    end
  end

  nfc_strobe u_strobe (
    .clk      (clk),
    .rst      (rst),
    .start    (stb_start),
    .strobe_n (stb_n),
    .sample   (stb_sample),
    .done     (stb_done)
  );

  always_comb
  begin
    pins_o                = pins_q;
    pins_o.write_strobe_n = stb_n || (op_q == nfc_pkg::OP_READ);
    pins_o.read_strobe_n  = stb_n || (op_q != nfc_pkg::OP_READ);
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_addr_strobe_use: assert property (pins_o.addr_latch |-> (op_q == nfc_pkg::OP_ADDR))
    else $error("address strobe high outside address load");
  a_cmd_strobe_use: assert property (pins_o.cmd_latch |-> (op_q == nfc_pkg::OP_CMD))
    else $error("command strobe high outside command load");
  a_bus_no_fight: assert property (!pins_o.read_strobe_n |-> !pins_o.io_oe)
    else $error("host drives bus during read strobe");
  a_one_select: assert property (pins_o.chip_select_n || pins_o.second_chip_select_n)
    else $error("both chip selects low");
  a_write_gated: assert property (!pins_o.write_strobe_n |-> !(pins_o.chip_select_n && pins_o.second_chip_select_n))
    else $error("write strobe without chip select");
  a_read_gated: assert property (!pins_o.read_strobe_n |-> !(pins_o.chip_select_n && pins_o.second_chip_select_n))
    else $error("read strobe without chip select");
  a_addr_pad_low: assert property (pins_o.addr_latch && (idx_q == 3'h1) && !pins_o.write_strobe_n |-> (pins_o.io_out[7:4] == 4'h0))
    else $error("address byte two upper nibble not low");
  a_addr_five_bytes: assert property ($fell(pins_o.addr_latch) |-> (idx_q == nfc_pkg::ADDR_LAST))
    else $error("address load cut short");
  a_ready_sync: assert property ((state_q == nfc_pkg::S_WAIT) && (guard_q == 8'h00) && !sel_q && $past(ready_busy_n, 2) && $past(ready_busy_n) && ready_busy_n |=> (state_q == nfc_pkg::S_IDLE))
    else $error("wait did not end on synchronised ready");
  a_wait_select_off: assert property ((state_q == nfc_pkg::S_WAIT) |=> pins_o.chip_select_n && pins_o.second_chip_select_n)
    else $error("chip select low during busy wait");

endmodule : nfc_host

/* design/nfc_strobe.sv */
// Purpose: one timed low pulse of a write or read strobe
// Assumes: start is a one-cycle pulse given only while idle
// Notes:   sample marks the last low cycle, done the last high cycle
module nfc_strobe (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic start,
  output logic      strobe_n,
  output logic      sample,
  output logic      done
);

  nfc_pkg::nfc_stb_t st_q, st_d;
  logic [7:0]        cnt_q, cnt_d;
  logic              stb_q, stb_d;

  // ----------------------------------------------------------------
  // pulse sequencing
  // ----------------------------------------------------------------
  always_comb
  begin
    st_d  = st_q;
    cnt_d = cnt_q;
    stb_d = stb_q;
    unique case (st_q)
      nfc_pkg::T_IDLE:
      begin
        if (start)
        begin
          st_d  = nfc_pkg::T_LOW;
          cnt_d = nfc_pkg::LOW_CYC - 8'h01;
          stb_d = 1'b0;
        end
      end
      nfc_pkg::T_LOW:
      begin
        if (cnt_q == 8'h00)
        begin
          st_d  = nfc_pkg::T_HIGH;
          cnt_d = nfc_pkg::HIGH_CYC - 8'h01;
          stb_d = 1'b1;
        end
        else
        begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      nfc_pkg::T_HIGH:
      begin
        if (cnt_q == 8'h00)
        begin
          st_d = nfc_pkg::T_IDLE;
        end
        else
        begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      default:
      begin
        st_d  = nfc_pkg::T_IDLE;
        stb_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_q  <= nfc_pkg::T_IDLE;
      cnt_q <= 8'h00;
      stb_q <= 1'b1;
    end
    else
    begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      stb_q <= stb_d;
    end
  end

  assign strobe_n = stb_q;
  assign sample   = (st_q == nfc_pkg::T_LOW) && (cnt_q == 8'h00);
  assign done     = (st_q == nfc_pkg::T_HIGH) && (cnt_q == 8'h00);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_strobe_low_width: assert property ($fell(strobe_n) |-> !strobe_n[*7] ##1 strobe_n)
    else $error("strobe low width wrong");
  a_strobe_high_gap: assert property ($rose(strobe_n) |-> strobe_n[*4])
    else $error("strobe high gap too short");

endmodule : nfc_strobe

/* include/nfc_pkg.sv */
// Purpose: shared constants and types of the NAND pin-interface host controller
// Assumes: one 250 MHz clock, synchronous active-high reset
// Notes:   register map, strobe timing, operation codes and pin bundle
package nfc_pkg;

  // ----------------------------------------------------------------
  // clock and pin timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ          = 250;
  localparam int unsigned T_STROBE_LOW_NS  = 25;
  localparam int unsigned T_STROBE_HIGH_NS = 15;
  localparam int unsigned T_BUSY_GUARD_NS  = 100;

  // least times round up, never below one cycle
  function automatic int unsigned min_cycles(input int unsigned t_ns);
    int unsigned c;
    c = (t_ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction : min_cycles

  localparam logic [7:0] LOW_CYC   = 8'(min_cycles(T_STROBE_LOW_NS));
  localparam logic [7:0] HIGH_CYC  = 8'(min_cycles(T_STROBE_HIGH_NS));
  localparam logic [7:0] GUARD_CYC = 8'(min_cycles(T_BUSY_GUARD_NS));

  // ----------------------------------------------------------------
  // bus and address widths
  // ----------------------------------------------------------------
  localparam int unsigned IO_W       = 8;
  localparam int unsigned COL_W      = 12;
  localparam int unsigned ROW_W      = 19;
  localparam logic [2:0]  ADDR_LAST  = 3'h4;

  // ----------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_DATA   = 8'h04;
  localparam logic [7:0] OFS_COL    = 8'h08;
  localparam logic [7:0] OFS_ROW    = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  localparam int unsigned CTRL_GO     = 0;
  localparam int unsigned CTRL_OP_LSB = 1;
  localparam int unsigned CTRL_SEL    = 4;
  localparam int unsigned CTRL_WP     = 5;
  localparam int unsigned STAT_BUSY   = 0;
  localparam int unsigned STAT_RDY0   = 1;
  localparam int unsigned STAT_RDY1   = 2;

  localparam logic        RST_SEL  = 1'b0;
  localparam logic        RST_WP_N = 1'b0;

  // ----------------------------------------------------------------
  // operations and states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_CMD   = 3'h0,
    OP_ADDR  = 3'h1,
    OP_WRITE = 3'h2,
    OP_READ  = 3'h3,
    OP_WAIT  = 3'h4
  } nfc_op_t;

  typedef enum logic [4:0] {
    S_IDLE   = 5'b00001,
    S_SETUP  = 5'b00010,
    S_LAUNCH = 5'b00100,
    S_STROBE = 5'b01000,
    S_WAIT   = 5'b10000
  } nfc_seq_t;

  typedef enum logic [2:0] {
    T_IDLE = 3'b001,
    T_LOW  = 3'b010,
    T_HIGH = 3'b100
  } nfc_stb_t;

  // ----------------------------------------------------------------
  // pin bundle driven toward the flash
  // ----------------------------------------------------------------
  typedef struct packed {
    logic            chip_select_n;
    logic            second_chip_select_n;
    logic            cmd_latch;
    logic            addr_latch;
    logic            write_strobe_n;
    logic            read_strobe_n;
    logic            write_protect_n;
    logic [IO_W-1:0] io_out;
    logic            io_oe;
  } nfc_pins_t;

endpackage : nfc_pkg

/* verif/nfc_flash_model.sv */
// Purpose: behavioural x8 flash device behind the host pins
// Assumes: host holds every pin for several clk cycles per strobe phase
// Notes:   busy time shortened to BUSY_CYC cycles; only the page register is kept
module nfc_flash_model #(
  parameter bit SEL      = 1'b0,
  parameter int BUSY_CYC = 40
) (
  input  wire logic               clk,
  input  wire nfc_pkg::nfc_pins_t pins,
  input  wire logic [7:0]         io_bus,
  output logic [7:0]              io_drv,
  output logic                    io_en,
  output logic                    rb_low
);
  timeunit 1ns;
  timeprecision 100ps;

  // one page of main plus spare bytes
  logic [7:0] pg [0:2111];
  logic [7:0] addr_b [0:4];
  logic [7:0] cmd_q  = 8'h00;
  int         addr_n = 0;
  int         busy_n = 0;
  int         ptr    = 0;
  logic       we_d   = 1'b1;
  logic       re_d   = 1'b1;
  logic       cs_n;
  logic [5:0]  page_sel;
  logic [12:0] block_sel;

  // row splits into block (plane in its low bit) and 64 pages
  assign page_sel  = addr_b[2][5:0];
  assign block_sel = {addr_b[4][2:0], addr_b[3], addr_b[2][7:6]};

  // each instance answers its own select only
  assign cs_n = SEL ? pins.second_chip_select_n : pins.chip_select_n;
  // drive the bus only under a selected read strobe
  assign io_en = !cs_n && !pins.read_strobe_n && busy_n == 0;
  assign io_drv = pg[ptr % 2112];
  // pull low while busy, whatever the select
  assign rb_low = busy_n != 0;

  always @(posedge clk)
  begin
    we_d <= pins.write_strobe_n;
    re_d <= pins.read_strobe_n;
    if (busy_n > 0)
      busy_n <= busy_n - 1;
    // latch at write strobe rise, selected only
    if (!cs_n && pins.write_strobe_n && !we_d)
    begin
      if (pins.cmd_latch && !pins.addr_latch && busy_n == 0)
      begin
        cmd_q  <= io_bus;
        addr_n <= 0;
        // read times itself; program and erase only with write_protect_n high
        if (io_bus == 8'h30 || ((io_bus == 8'h10 || io_bus == 8'hd0) && pins.write_protect_n))
          busy_n <= BUSY_CYC;
      end
      // address bytes; column pointer from the first two
      else if (pins.addr_latch && !pins.cmd_latch && addr_n < 5)
      begin
        addr_b[addr_n] <= io_bus;
        addr_n <= addr_n + 1;
        if (addr_n == 1)
          ptr <= {io_bus[3:0], addr_b[0]};
      end
      // data only while idle and both latches low
      else if (!pins.cmd_latch && !pins.addr_latch && busy_n == 0)
      begin
        pg[ptr % 2112] <= io_bus;
        ptr <= ptr + 1;
      end
    end
    if (!cs_n && pins.read_strobe_n && !re_d)
      ptr <= ptr + 1;
  end
endmodule : nfc_flash_model

/* verif/nfc_host_tb_top.sv */
// Purpose: self-checking bench of the flash pin host controller
// Assumes: two device models, pull-ups on both ready/busy wires
// Notes:   a floating io bus shows the inverse of its last value
module nfc_host_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [7:0] EXP_ADDR [5] = '{8'h3f, 8'h08, 8'hc5, 8'hb2, 8'h06};
  logic               clk     = 1'b0;
  logic               rst     = 1'b1;
  logic               psel    = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite  = 1'b0;
  logic [7:0]         paddr   = 8'h00;
  logic [31:0]        pwdata  = 32'h0;
  logic [31:0]        prdata, rd;
  logic               pready, pslverr, err, en0, en1, low0, low1;
  logic               wp_n    = 1'b0;
  nfc_pkg::nfc_pins_t pins;
  logic [7:0]         io_bus, drv0, drv1;
  logic [7:0]         io_last = 8'h00;
  logic [2:0]         bad;
  int                 error_cnt = 0;
  int                 checks_done = 0;

  always #2 clk = ~clk;
  assign io_bus = pins.io_oe ? pins.io_out : en0 ? drv0 : en1 ? drv1 : ~io_last;
  always @(posedge clk) io_last <= io_bus;

  nfc_host dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins_o(pins), .io_in(io_bus),
    .ready_busy_n(!low0), .second_ready_busy_n(!low1));
  nfc_flash_model #(.SEL(1'b0)) dev0 (.clk(clk), .pins(pins), .io_bus(io_bus), .io_drv(drv0), .io_en(en0),
    .rb_low(low0));
  nfc_flash_model #(.SEL(1'b1)) dev1 (.clk(clk), .pins(pins), .io_bus(io_bus), .io_drv(drv1), .io_en(en1),
    .rb_low(low1));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    if (error_cnt == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // no wait-state count assumed: the access phase lasts until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      error_cnt++;
      conclude();
    end
  endtask : apb

  task automatic op(input nfc_pkg::nfc_op_t code, input logic [7:0] b, input logic s);
    int n;
    if (code == nfc_pkg::OP_CMD || code == nfc_pkg::OP_WRITE)
      apb(1'b1, nfc_pkg::OFS_DATA, {24'h0, b});
    apb(1'b1, nfc_pkg::OFS_CTRL, {26'h0, wp_n, s, code, 1'b1});
    n = 0;
    do
    begin
      apb(1'b0, nfc_pkg::OFS_STATUS, 32'h0);
      n++;
    end
    while (rd[nfc_pkg::STAT_BUSY] !== 1'b0 && n < 200);
    if (n >= 200)
    begin
      error_cnt++;
      conclude();
    end
  endtask : op

  task automatic ready_lines(input logic [1:0] exp);
    apb(1'b0, nfc_pkg::OFS_STATUS, 32'h0);
    check({30'h0, rd[2:1]}, {30'h0, exp});
  endtask : ready_lines

  // latches exclusive, no bus fight, strobes only when selected
  assign bad = {pins.cmd_latch & pins.addr_latch, pins.io_oe & (en0 | en1),
                ~(pins.write_strobe_n & pins.read_strobe_n) & pins.chip_select_n & pins.second_chip_select_n};
  always @(posedge clk)
    if (!rst)
      check({29'h0, bad}, 32'h0);

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    check({16'h0, pins}, {16'h0, 2'b11, 2'b00, 2'b11, 1'b0, 8'h00, 1'b0});
    ready_lines(2'b11);
    apb(1'b0, 8'h20, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
  endtask : t_reset

  task automatic t_program();
    apb(1'b1, nfc_pkg::OFS_COL, 32'h83f);
    apb(1'b1, nfc_pkg::OFS_ROW, 32'h6b2c5);
    op(nfc_pkg::OP_CMD, 8'h80, 1'b0);
    op(nfc_pkg::OP_ADDR, 8'h00, 1'b0);
    for (int i = 0; i < 5; i++)
      check({24'h0, dev0.addr_b[i]}, {24'h0, EXP_ADDR[i]});
    check({26'h0, dev0.page_sel}, 32'h05);
    check({19'h0, dev0.block_sel}, 32'h1acb);
    op(nfc_pkg::OP_WRITE, 8'h5a, 1'b0);
    check({24'h0, dev0.pg[12'h83f]}, 32'h5a);
    op(nfc_pkg::OP_CMD, 8'h10, 1'b0);
    ready_lines(2'b11);
    wp_n = 1'b1;
    op(nfc_pkg::OP_CMD, 8'h10, 1'b0);
    ready_lines(2'b10);
    op(nfc_pkg::OP_WAIT, 8'h00, 1'b0);
    check(dev0.busy_n, 32'h0);
    ready_lines(2'b11);
  endtask : t_program

  task automatic t_read();
    op(nfc_pkg::OP_CMD, 8'h00, 1'b0);
    op(nfc_pkg::OP_ADDR, 8'h00, 1'b0);
    op(nfc_pkg::OP_CMD, 8'h30, 1'b0);
    op(nfc_pkg::OP_CMD, 8'h80, 1'b0);
    check({24'h0, dev0.cmd_q}, 32'h30);
    op(nfc_pkg::OP_WAIT, 8'h00, 1'b0);
    check(dev0.busy_n, 32'h0);
    op(nfc_pkg::OP_READ, 8'h00, 1'b0);
    apb(1'b0, nfc_pkg::OFS_DATA, 32'h0);
    check(rd, 32'h5a);
  endtask : t_read

  task automatic t_second();
    op(nfc_pkg::OP_CMD, 8'hd0, 1'b1);
    ready_lines(2'b01);
    check({24'h0, dev0.cmd_q}, 32'h30);
    op(nfc_pkg::OP_WAIT, 8'h00, 1'b1);
    check(dev1.busy_n, 32'h0);
    ready_lines(2'b11);
  endtask : t_second

  initial
  begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    conclude();
  end

  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    t_reset();
    t_program();
    t_read();
    t_second();
    conclude();
  end
endmodule : nfc_host_tb_top
